// ### eeprom_ctl_regs.vh
// Timing and encoding constants for the nonvolatile memory controller
`ifndef EEPROM_CTL_REGS_VH
`define EEPROM_CTL_REGS_VH
`define CLK_MHZ          25
`define CYCLE_TIME_US    9000
`define CYCLE_COUNT      (`CYCLE_TIME_US * `CLK_MHZ)
`define SETUP_TIME_NS    350
`define SETUP_COUNT      ((`SETUP_TIME_NS * `CLK_MHZ + 999) / 1000 + 1)
`define PULSE_TIME_NS    150
`define PULSE_COUNT      ((`PULSE_TIME_NS * `CLK_MHZ + 999) / 1000)
`define ACCESS_TIME_NS   200
`define ACCESS_COUNT     ((`ACCESS_TIME_NS * `CLK_MHZ + 999) / 1000 + 2)
`define OP_READ          3'h0
`define OP_WRITE         3'h1
`define OP_WORD_ERASE    3'h2
`define OP_WORD_ERASE_HV 3'h3
`define OP_ROW_ERASE     3'h4
`define OP_COL_ERASE     3'h5
`define OP_BULK_ERASE    3'h6
`define ADDR_W           12
`define DATA_W           8
`endif

// ### pin_sync.v
// Two-flop synchroniser for a bus of pin inputs
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             core_clk_i,
  input  wire             reset_n_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage1;
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// ### eeprom_ctl.v
// Host-side controller sequencing mode pins of a 4096 x 8 erasable memory
`include "eeprom_ctl_regs.vh"
// What this block does
// - Select and output drive low, strobe high reads addressed byte.
// - Select low, drive high, strobe low writes the presented byte.
// - Word erase at logic levels: as write with all byte lines high.
// - Alternate word erase raises strobe to high voltage, lines high.
// - Allow about 9 ms per write or erase before location is updated.
// - Return select high over 350 ns before new index, controls, data.
module eeprom_ctl (
  input  wire                 core_clk_i,
  input  wire                 reset_n_i,
  input  wire                 req_valid_i,
  output wire                 req_ready_o,
  input  wire [2:0]           req_op_i,
  input  wire [`ADDR_W-1:0]   req_index_i,
  input  wire [`DATA_W-1:0]   req_data_i,
  output reg                  rsp_valid_o,
  output reg  [`DATA_W-1:0]   rsp_data_o,
  output reg                  busy_o,
  output reg  [`ADDR_W-1:0]   location_index_o,
  input  wire [`DATA_W-1:0]   byte_lines_i,
  output reg  [`DATA_W-1:0]   byte_lines_o,
  output reg                  byte_lines_oe_o,
  output reg                  select_n_o,
  output reg                  drive_n_o,
  output reg                  drive_hv_o,
  output reg                  strobe_n_o,
  output reg                  strobe_hv_o
);
  localparam [5:0] S_IDLE   = 6'h01;
  localparam [5:0] S_SETUP  = 6'h02;
  localparam [5:0] S_ACCESS = 6'h04;
  localparam [5:0] S_PULSE  = 6'h08;
  localparam [5:0] S_CYCLE  = 6'h10;
  localparam [5:0] S_DONE   = 6'h20;
  localparam integer CYCLE_I  = `CYCLE_COUNT;
  localparam integer SETUP_I  = `SETUP_COUNT;
  localparam integer PULSE_I  = `PULSE_COUNT;
  localparam integer ACCESS_I = `ACCESS_COUNT;
  // Counts cut to the counter width on purpose; all fit in 23 bits
  localparam [22:0]  CYCLE_N  = CYCLE_I[22:0];
  localparam [22:0]  SETUP_N  = SETUP_I[22:0];
  localparam [22:0]  PULSE_N  = PULSE_I[22:0];
  localparam [22:0]  ACCESS_N = ACCESS_I[22:0];

  reg  [5:0]         state;
  reg  [22:0]        count;
  reg  [2:0]         op;
  wire [`DATA_W-1:0] byte_sync;

  // Erase modes need byte lines held high
  function is_erase;
    input [2:0] code;
    begin
      is_erase = (code != `OP_READ) && (code != `OP_WRITE);
    end
  endfunction

  pin_sync #(.WIDTH(`DATA_W)) u_sync (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    (byte_lines_i),
    .sync_o     (byte_sync)
  );

  assign req_ready_o = (state == S_IDLE);

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state            <= S_SETUP;
      count            <= 23'h000000;
      op               <= `OP_READ;
      rsp_valid_o      <= 1'b0;
      rsp_data_o       <= 8'h00;
      busy_o           <= 1'b1;
      location_index_o <= 12'h000;
      byte_lines_o     <= 8'hFF;
      byte_lines_oe_o  <= 1'b0;
      select_n_o       <= 1'b1;
      drive_n_o        <= 1'b1;
      drive_hv_o       <= 1'b0;
      strobe_n_o       <= 1'b1;
      strobe_hv_o      <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      case (state)
        S_SETUP: begin
          // Select held high (standby) long enough to reopen device latches
          select_n_o <= 1'b1;
          if (count >= SETUP_N - 23'h000001) begin
            count  <= 23'h000000;
            state  <= S_IDLE;
            busy_o <= 1'b0;
          end else begin
            count <= count + 23'h000001;
          end
        end
        S_IDLE: begin
          if (req_valid_i) begin
            op               <= req_op_i;
            busy_o           <= 1'b1;
            location_index_o <= req_index_i;
            count            <= 23'h000000;
            drive_hv_o       <= 1'b0;
            strobe_hv_o      <= 1'b0;
            drive_n_o        <= 1'b1;
            strobe_n_o       <= 1'b1;
            byte_lines_oe_o  <= 1'b0;
            // Controls are set with select, captured at its fall
            select_n_o       <= 1'b0;
            case (req_op_i)
              `OP_READ: begin
                drive_n_o <= 1'b0;
                state     <= S_ACCESS;
              end
              `OP_WRITE: begin
                strobe_n_o      <= 1'b0;
                byte_lines_o    <= req_data_i;
                byte_lines_oe_o <= 1'b1;
                state           <= S_PULSE;
              end
              `OP_WORD_ERASE: begin
                strobe_n_o      <= 1'b0;
                byte_lines_o    <= 8'hFF;
                byte_lines_oe_o <= 1'b1;
                state           <= S_PULSE;
              end
              `OP_WORD_ERASE_HV: begin
                strobe_hv_o     <= 1'b1;
                byte_lines_o    <= 8'hFF;
                byte_lines_oe_o <= 1'b1;
                state           <= S_PULSE;
              end
              `OP_ROW_ERASE: begin
                drive_hv_o      <= 1'b1;
                strobe_hv_o     <= 1'b1;
                byte_lines_o    <= 8'hFF;
                byte_lines_oe_o <= 1'b1;
                state           <= S_PULSE;
              end
              `OP_COL_ERASE: begin
                drive_hv_o      <= 1'b1;
                byte_lines_o    <= 8'hFF;
                byte_lines_oe_o <= 1'b1;
                state           <= S_PULSE;
              end
              `OP_BULK_ERASE: begin
                drive_hv_o      <= 1'b1;
                strobe_n_o      <= 1'b0;
                byte_lines_o    <= 8'hFF;
                byte_lines_oe_o <= 1'b1;
                state           <= S_PULSE;
              end
              default: begin
                select_n_o <= 1'b1;
                busy_o     <= 1'b0;
                state      <= S_IDLE;
              end
            endcase
          end
        end
        S_ACCESS: begin
          if (count >= ACCESS_N - 23'h000001) begin
            rsp_data_o  <= byte_sync;
            rsp_valid_o <= 1'b1;
            drive_n_o   <= 1'b1;
            select_n_o  <= 1'b1;
            count       <= 23'h000000;
            state       <= S_SETUP;
          end else begin
            count <= count + 23'h000001;
          end
        end
        S_PULSE: begin
          if (count >= PULSE_N - 23'h000001) begin
            // Strobe rise latches the byte; select stays low for the cycle
            if (op == `OP_WRITE || op == `OP_WORD_ERASE) begin
              strobe_n_o <= 1'b1;
            end
            count <= 23'h000000;
            state <= S_CYCLE;
          end else begin
            count <= count + 23'h000001;
          end
        end
        S_CYCLE: begin
          if (count == PULSE_N && is_erase(op)) begin
            byte_lines_o <= 8'hFF;
          end
          if (count >= CYCLE_N - 23'h000001) begin
            // Full 9 ms select pulse before result is trusted
            select_n_o      <= 1'b1;
            drive_hv_o      <= 1'b0;
            strobe_hv_o     <= 1'b0;
            drive_n_o       <= 1'b1;
            strobe_n_o      <= 1'b1;
            byte_lines_oe_o <= 1'b0;
            count           <= 23'h000000;
            state           <= S_DONE;
          end else begin
            count <= count + 23'h000001;
          end
        end
        S_DONE: begin
          rsp_valid_o <= 1'b1;
          rsp_data_o  <= 8'h00;
          state       <= S_SETUP;
        end
        default: begin
          state <= S_SETUP;
        end
      endcase
    end
  end
endmodule

// ### eeprom_ctl_props.sv
// Concurrent checks on the mode pins of the memory controller
module eeprom_ctl_props (
  input wire logic       core_clk_i, reset_n_i, req_valid_i, req_ready_o, rsp_valid_o, busy_o,
  input wire logic       byte_lines_oe_o, select_n_o, drive_n_o, drive_hv_o, strobe_n_o, strobe_hv_o,
  input wire logic [2:0] req_op_i,
  input wire logic [7:0] byte_lines_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_DRIVE_ONLY_WRITING: assert property (byte_lines_oe_o |-> !select_n_o && drive_n_o)
    else $error("byte lines driven outside a write");
  AST_NO_DRIVE_ON_READ: assert property (!drive_n_o |-> !byte_lines_oe_o)
    else $error("byte lines driven during a read");
  AST_ERASE_ALL_ONES: assert property (byte_lines_oe_o && (drive_hv_o || strobe_hv_o) |-> byte_lines_o == 8'hFF)
    else $error("erase without all byte lines high");
  AST_READY_IN_IDLE: assert property (req_ready_o |-> select_n_o && !busy_o)
    else $error("ready while selected or busy");
  AST_SELECT_GAP: assert property ($rose(select_n_o) |-> !req_ready_o [*8])
    else $error("select high too briefly before next request");
  AST_RSP_ONE_CYCLE: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("response longer than one cycle");
  AST_STROBE_PULSE: assert property ($fell(strobe_n_o) && !drive_hv_o && !strobe_hv_o |-> !strobe_n_o [*4] ##1 strobe_n_o)
    else $error("strobe pulse not four cycles");
  AST_READ_ACCESS: assert property ($fell(drive_n_o) && !drive_hv_o |-> !select_n_o [*7] ##1 rsp_valid_o)
    else $error("read answer not after seven cycles");
  AST_TAKE_MAKES_BUSY: assert property (req_valid_i && req_ready_o && req_op_i != 3'h7 |=> busy_o)
    else $error("accepted request without busy");
  AST_WRITE_HOLDS_SELECT: assert property ($fell(select_n_o) && drive_n_o |-> !select_n_o [*8])
    else $error("select released early in a store cycle");
endmodule

// ### eeprom_model.sv
// Behavioural model of the erasable memory on the far side
module eeprom_model (
  input  wire logic        sel_n, drive_n, drive_hv, strobe_n, strobe_hv,
  input  wire logic [11:0] idx,
  input  wire logic [7:0]  lines_in,
  output logic      [7:0]  lines_out,
  output logic             lines_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:4095];
  logic [11:0] a;
  logic [1:0]  hv;
  logic        wr;
  logic        armed = 1'b0;
  logic [7:0]  d;
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
  assign lines_oe  = !sel_n && !drive_n && strobe_n && !strobe_hv;
  assign lines_out = mem[idx];
  always @(negedge sel_n) begin
    a     = idx;
    hv    = {drive_hv, strobe_hv};
    wr    = !strobe_n;
    armed = 1'b1;
  end
  always @(posedge strobe_n) d = lines_in;
  // Commit at cycle end only after a select fall; power-up edges store nothing
  always @(posedge sel_n) begin
    if (armed) begin
      for (int i = 0; i < 4096; i++)
        if (hv == 2'h3 ? i[11:5] == a[11:5] : hv == 2'h2 ? (wr || i[4:0] == a[4:0]) : 1'b0) mem[i] = 8'hFF;
      if (hv == 2'h1) mem[a] = 8'hFF;
      else if (hv == 2'h0 && wr) mem[a] = (d == 8'hFF) ? 8'hFF : (mem[a] & d);
    end
    armed = 1'b0;
  end
endmodule

// ### eeprom_ctl_test.sv
// Self-checking bench for the memory controller
module eeprom_ctl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_n = 0, valid = 0;
  logic [2:0]  op = 0;
  logic [11:0] idx = 0;
  logic [7:0]  wd = 0, last = 0;
  wire         ready, rv, busy, oe, sn, dn, dhv, stn, shv, m_oe;
  wire  [7:0]  rd, bl_o, m_dq, bl;
  wire  [11:0] loc;
  int          miscompares = 0, n_checks = 0;
  always #20 clk = ~clk;
  // Released lines show the inverse of the last driven level
  assign bl = oe ? bl_o : (m_oe ? m_dq : ~last);
  always @(posedge clk) if (oe || m_oe) last <= bl;
  eeprom_ctl dut (.core_clk_i(clk), .reset_n_i(rst_n), .req_valid_i(valid), .req_ready_o(ready), .req_op_i(op),
    .req_index_i(idx), .req_data_i(wd), .rsp_valid_o(rv), .rsp_data_o(rd), .busy_o(busy), .location_index_o(loc),
    .byte_lines_i(bl), .byte_lines_o(bl_o), .byte_lines_oe_o(oe), .select_n_o(sn), .drive_n_o(dn),
    .drive_hv_o(dhv), .strobe_n_o(stn), .strobe_hv_o(shv));
  eeprom_model mdl (.sel_n(sn), .drive_n(dn), .drive_hv(dhv), .strobe_n(stn), .strobe_hv(shv), .idx(loc),
    .lines_in(bl), .lines_out(m_dq), .lines_oe(m_oe));
  task chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task results;
    $display("Checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task do_reset;
    int n;
    rst_n <= 0;
    valid <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (ready !== 1 && n < 40);
    chk("ready", 1, ready);
    chk("setup gap", 1, n >= 10);
    if (n >= 40) results;
  endtask
  task send(input logic [2:0] o, input logic [11:0] i, input logic [7:0] d);
    int n;
    op <= o;
    idx <= i;
    wd <= d;
    valid <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (ready !== 1 && n < 40);
    valid <= 0;
    if (n >= 40) begin chk("take", 1, 0); results; end
  endtask
  task t_read(input logic [11:0] i);
    int n;
    send(3'h0, i, 8'h00);
    n = 0;
    do begin @(posedge clk); n++; end while (rv !== 1 && n < 30);
    chk("read valid", 1, rv);
    chk("read data", {4'h0, i[7:0] ^ 8'hA5}, {4'h0, rd});
    if (n >= 30) results;
  endtask
  task t_drop;
    logic bad;
    bad = 0;
    send(3'h7, 12'h000, 8'h00);
    repeat (5) begin @(posedge clk); if (rv !== 0 || sn !== 1) bad = 1; end
    chk("dropped op", 0, bad);
    chk("ready after drop", 1, ready);
  endtask
  // Start a store cycle, check the mode pins, then abort it by reset
  task t_mode(input logic [2:0] o, input logic [1:0] hv);
    send(o, 12'hA5C, 8'h3C);
    repeat (3) @(posedge clk);
    chk("hv pins", hv, {dhv, shv});
    chk("drive strobe", (o == 3'h1 || o == 3'h2 || o == 3'h6) ? 2'h2 : 2'h3, {dn, stn});
    chk("lines", (o == 3'h1) ? 8'h3C : 8'hFF, bl_o);
    chk("oe", 1, oe);
    chk("select", 0, sn);
    chk("index", 12'hA5C, loc);
    valid <= 1;
    repeat (20) @(posedge clk);
    chk("refused", 3'h2, {ready, busy, sn});
    chk("strobe after", (o == 3'h6) ? 1'b0 : 1'b1, stn);
    do_reset;
  endtask
  initial begin
    do_reset;
    t_read(12'h000);
    t_read(12'hFFF);
    t_read(12'h5A3);
    t_drop;
    t_mode(3'h1, 2'h0);
    t_mode(3'h2, 2'h0);
    t_mode(3'h3, 2'h1);
    t_mode(3'h4, 2'h3);
    t_mode(3'h5, 2'h2);
    t_mode(3'h6, 2'h2);
    results;
  end
endmodule
bind eeprom_ctl eeprom_ctl_props chk_i (.*);
